/* rtl/sfp_front.sv */
// serial front end: framing, hold, protection, OTP lock and program data path
`include "sfp_defs.svh"
module sfp_front #(
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // serial pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        si,
    input  wire logic        wp_n,
    input  wire logic        hold_n,
    output logic             so,
    output logic             so_oe,
    // device state from the core
    input  wire logic        quad_mode,
    input  wire logic        busy,
    input  wire logic        factory_lock,
    input  wire logic [7:0]  read_data,
    // requests toward the core
    output logic             erase_req,
    output logic [1:0]       erase_size,
    output logic             prog_start,
    output logic [18:0]      op_addr,
    output logic             otp_mode,
    output logic             otp_select,
    // program data stream
    output logic [7:0]       prog_data,
    output logic             prog_valid,
    input  wire logic        prog_ready,
    // status
    output logic [7:0]       status,
    output logic             customer_lock,
    output logic             paused,
    output logic             active,
    output logic             rejected
);
    import sfp_pkg::*;

    // ***********************************
    // pin synchronisers
    // ***********************************
    logic [4:0] meta;
    logic [4:0] sync;
    logic [4:0] prev;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta <= 5'h1d;
            sync <= 5'h1d;
            prev <= 5'h1d;
        end else begin
            meta <= {hold_n, wp_n, si, sclk, cs_n};
            sync <= meta;
            prev <= sync;
        end
    end
    logic s_cs_n;
    logic s_clk;
    logic s_si;
    logic s_wp_n;
    logic s_hold_n;
    assign {s_hold_n, s_wp_n, s_si, s_clk, s_cs_n} = sync;
    logic clk_rise;
    logic clk_fall;
    logic cs_rise;
    logic cs_fall;
    assign clk_rise = s_clk && !prev[1];
    assign clk_fall = !s_clk && prev[1];
    assign cs_rise  = s_cs_n && !prev[0];
    assign cs_fall  = !s_cs_n && prev[0];

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        sfp_state_t  st;
        sfp_kind_t   kind;
        logic [7:0]  op;
        logic [7:0]  shreg;
        logic [2:0]  bitcnt;
        logic [1:0]  bytecnt;
        logic [18:0] addr;
        logic [7:0]  outreg;
        logic        hold;
        logic        write_enable_latch;
        logic [3:0]  bp;
        logic        tb;
        logic        status_write_disable;
        logic        clock;
        logic        otp;
        logic        erase_req;
        logic [1:0]  erase_size;
        logic        prog_start;
        logic [7:0]  pdata;
        logic        pvalid;
        logic        so;
        logic        so_oe;
        logic        rejected;
    } sfp_regs_t;
    sfp_regs_t r;
    sfp_regs_t next_r;
    logic      fifo_ready;

    // protected-block mask for a block index
    function automatic logic blk_protected(input logic [3:0] bp, input logic tb, input logic [2:0] blk);
        logic [2:0] idx;
        idx = tb ? blk : ~blk;
        case (bp)
            4'h0: blk_protected = 1'b0;
            4'h1: blk_protected = idx == 3'h0;
            4'h2: blk_protected = idx <= 3'h1;
            4'h3: blk_protected = idx <= 3'h3;
            default: blk_protected = 1'b1;
        endcase
    endfunction

    // can the addressed location be written
    function automatic logic target_ok(input sfp_regs_t s, input logic [18:0] a, input logic flock);
        if (s.otp) begin
            // only low ten bits pick the OTP byte
            target_ok = a[`SFP_OTP_HALF] ? !flock : !s.clock;
        end else begin
            target_ok = !blk_protected(s.bp, s.tb, a[`SFP_BLK_MSB:`SFP_BLK_LSB]);
        end
    endfunction

    logic [7:0] cur_status;
    assign cur_status = {r.status_write_disable, r.tb, r.bp, r.write_enable_latch, busy};

    always_comb begin
        logic [7:0] byte_in;
        logic       byte_done;
        logic       wr_locked;
        next_r = r;
        byte_in = {r.shreg[6:0], s_si};
        byte_done = r.bitcnt == `SFP_LAST_BIT;
        wr_locked = !s_wp_n && r.status_write_disable && !quad_mode;
        next_r.erase_req = 1'b0;
        next_r.prog_start = 1'b0;
        if (r.pvalid && fifo_ready) begin
            next_r.pvalid = 1'b0;
        end
        // hold only toggles with the serial clock low
        if (!quad_mode && !s_cs_n && !s_clk) begin
            next_r.hold = !s_hold_n;
        end
        if (quad_mode) begin
            next_r.hold = 1'b0;
        end
        if (cs_rise) begin
            // frame end: state-changing commands other than page program act only here, on a byte boundary
            next_r.st = SFP_IDLE;
            next_r.hold = 1'b0;
            next_r.so_oe = 1'b0;
            // a refusal made inside the frame stands until the next select fall
            if (r.bitcnt != 3'h0 && r.kind != SFP_K_NONE) begin
                next_r.rejected = 1'b1;
            end else if (!r.hold && r.st != SFP_STBY) begin
                case (r.kind)
                    SFP_K_SIMPLE: begin
                        case (r.op)
                            `SFP_OP_WRITE_ENABLE_CMD: next_r.write_enable_latch = 1'b1;
                            `SFP_OP_WRDI: next_r.write_enable_latch = 1'b0;
                            `SFP_OP_OTP_MODE_ENTER_CMD: next_r.otp = 1'b1;
                            `SFP_OP_OTP_MODE_EXIT_CMD: next_r.otp = 1'b0;
                            `SFP_OP_SECURITY_REG_WRITE_CMD: begin
                                if (r.write_enable_latch && !busy) begin
                                    next_r.clock = 1'b1;
                                    next_r.write_enable_latch = 1'b0;
                                end else begin
                                    next_r.rejected = 1'b1;
                                end
                            end
                            default: next_r.rejected = 1'b0;
                        endcase
                    end
                    SFP_K_WRSR: begin
                        if (r.write_enable_latch && !busy && !wr_locked && r.bytecnt != 2'h0) begin
                            next_r.bp = r.pdata[`SFP_ST_BP_LO +: 4];
                            next_r.tb = r.pdata[`SFP_ST_TB];
                            next_r.status_write_disable = r.pdata[`SFP_ST_STATUS_WRITE_DISABLE];
                            next_r.write_enable_latch = 1'b0;
                        end else begin
                            next_r.rejected = 1'b1;
                        end
                    end
                    SFP_K_CHIP: begin
                        if (r.write_enable_latch && !busy && r.bp == 4'h0 && !r.otp) begin
                            next_r.erase_req = 1'b1;
                            next_r.erase_size = 2'h3;
                            next_r.write_enable_latch = 1'b0;
                        end else begin
                            next_r.rejected = 1'b1;
                        end
                    end
                    SFP_K_ERASE: begin
                        if (r.write_enable_latch && !busy && !r.otp && r.bytecnt == `SFP_ADDR_BYTES
                            && target_ok(r, r.addr, factory_lock)) begin
                            next_r.erase_req = 1'b1;
                            next_r.write_enable_latch = 1'b0;
                        end else begin
                            next_r.rejected = 1'b1;
                        end
                    end
                    SFP_K_PROG: begin
                        next_r.write_enable_latch = 1'b0;
                    end
                    default: next_r.write_enable_latch = r.write_enable_latch;
                endcase
            end
            next_r.kind = SFP_K_NONE;
        end else if (s_cs_n) begin
            next_r.st = SFP_IDLE;
            next_r.so_oe = 1'b0;
        end else if (cs_fall) begin
            next_r.st = SFP_CMD;
            next_r.bitcnt = 3'h0;
            next_r.bytecnt = 2'h0;
            next_r.kind = SFP_K_NONE;
            next_r.rejected = 1'b0;
        end else if (r.hold) begin
            next_r.so_oe = 1'b0;
        end else if (clk_rise && r.st != SFP_STBY && r.st != SFP_IDLE) begin
            next_r.shreg = byte_in;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (byte_done) begin
                case (r.st)
                    SFP_CMD: begin
                        next_r.op = byte_in;
                        next_r.st = SFP_ADDR;
                        case (byte_in)
                            `SFP_OP_WRITE_ENABLE_CMD, `SFP_OP_WRDI, `SFP_OP_OTP_MODE_ENTER_CMD, `SFP_OP_OTP_MODE_EXIT_CMD,
                            `SFP_OP_SECURITY_REG_WRITE_CMD: begin
                                next_r.kind = SFP_K_SIMPLE;
                                next_r.st = SFP_DATA;
                            end
                            `SFP_OP_CE1, `SFP_OP_CE2: begin
                                next_r.kind = SFP_K_CHIP;
                                next_r.st = SFP_DATA;
                            end
                            `SFP_OP_WRSR: begin
                                next_r.kind = SFP_K_WRSR;
                                next_r.st = SFP_DATA;
                            end
                            `SFP_OP_SE: begin
                                next_r.kind = SFP_K_ERASE;
                                next_r.erase_size = 2'h0;
                            end
                            `SFP_OP_BE32: begin
                                next_r.kind = SFP_K_ERASE;
                                next_r.erase_size = 2'h1;
                            end
                            `SFP_OP_BE64: begin
                                next_r.kind = SFP_K_ERASE;
                                next_r.erase_size = 2'h2;
                            end
                            `SFP_OP_PP: next_r.kind = SFP_K_PROG;
                            `SFP_OP_READ, `SFP_OP_FREAD: next_r.kind = SFP_K_NONE;
                            `SFP_OP_RDSR: begin
                                next_r.st = SFP_OUT;
                                next_r.outreg = cur_status;
                            end
                            `SFP_OP_RDSCUR: begin
                                next_r.st = SFP_OUT;
                                next_r.outreg = {6'h0, r.clock, factory_lock};
                            end
                            `SFP_OP_RDCR: begin
                                next_r.st = SFP_OUT;
                                next_r.outreg = 8'h00;
                            end
                            default: next_r.st = SFP_STBY;
                        endcase
                    end
                    SFP_ADDR: begin
                        next_r.addr = {r.addr[10:0], byte_in};
                        next_r.bytecnt = r.bytecnt + 2'h1;
                        if (r.bytecnt == 2'h2) begin
                            if (r.kind == SFP_K_NONE) begin
                                // reads ignored while busy; OTP mode does not stop them
                                if (busy) begin
                                    next_r.st = SFP_STBY;
                                end else begin
                                    next_r.st = SFP_OUT;
                                    next_r.outreg = read_data;
                                end
                            end else begin
                                next_r.st = SFP_DATA;
                                if (r.otp) begin
                                    next_r.addr = {9'h0, r.addr[1:0], byte_in};
                                end
                            end
                        end
                    end
                    SFP_DATA: begin
                        next_r.bytecnt = (r.bytecnt == 2'h3) ? r.bytecnt : r.bytecnt + 2'h1;
                        if (r.kind == SFP_K_WRSR) begin
                            next_r.pdata = byte_in;
                            next_r.bytecnt = 2'h1;
                        end else if (r.kind == SFP_K_PROG) begin
                            if (!r.write_enable_latch || busy || !target_ok(r, r.addr, factory_lock)) begin
                                next_r.st = SFP_STBY;
                                next_r.rejected = 1'b1;
                            end else if (fifo_ready || !r.pvalid) begin
                                next_r.pdata = byte_in;
                                next_r.pvalid = 1'b1;
                                next_r.prog_start = 1'b1;
                            end
                        end else begin
                            next_r.kind = r.kind;
                        end
                    end
                    SFP_OUT: begin
                        next_r.outreg = r.op == `SFP_OP_RDSR ? cur_status : read_data;
                    end
                    default: next_r.st = SFP_STBY;
                endcase
            end
        end else if (clk_fall && r.st == SFP_OUT) begin
            // drive next bit; frame may end after any bit
            next_r.so = r.outreg[3'h7 - r.bitcnt];
            next_r.so_oe = 1'b1;
        end
        if (r.st == SFP_STBY) begin
            next_r.so_oe = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= '{st: SFP_IDLE, kind: SFP_K_NONE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ***********************************
    // program data buffer
    // ***********************************
    logic [7:0] fifo_data;
    logic       fifo_valid;
    sfp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_data   (r.pdata),
        .in_valid  (r.pvalid),
        .in_ready  (fifo_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (!prog_valid || prog_ready)
    );
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prog_valid <= 1'b0;
            prog_data  <= 8'h00;
        end else if (!prog_valid || prog_ready) begin
            prog_valid <= fifo_valid;
            prog_data  <= fifo_data;
        end
    end

    // ***********************************
    // registered outputs
    // ***********************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            so            <= 1'b0;
            so_oe         <= 1'b0;
            erase_req     <= 1'b0;
            erase_size    <= 2'h0;
            prog_start    <= 1'b0;
            op_addr       <= '0;
            otp_mode      <= 1'b0;
            otp_select    <= 1'b0;
            status        <= 8'h00;
            customer_lock <= 1'b0;
            paused        <= 1'b0;
            active        <= 1'b0;
            rejected      <= 1'b0;
        end else begin
            so            <= r.so;
            so_oe         <= r.so_oe && !r.hold;
            erase_req     <= r.erase_req;
            erase_size    <= r.erase_size;
            prog_start    <= r.prog_start;
            op_addr       <= r.addr;
            otp_mode      <= r.otp;
            otp_select    <= r.addr[`SFP_OTP_HALF];
            status        <= cur_status;
            customer_lock <= r.clock;
            paused        <= r.hold;
            active        <= r.st != SFP_IDLE && r.st != SFP_STBY;
            rejected      <= r.rejected;
        end
    end
endmodule // sfp_front

/* rtl/sfp_defs.svh */
// constants for the serial flash protect/hold front end
//
// Notes on behaviour
// - top select clear: level 0 none, 1/2/3 top 1/2/4 blocks, 4+ all eight
// - top select set: same levels counted from block 0 upward
// - whole-chip erase accepted only when all four protect-level bits are zero
// - 8K-bit OTP area: lower half 000-1FF customer lock, upper 200-3FF factory lock
// - security register bit 0 shows factory lock of the upper OTP half
// - security write command sets customer lock, security register bit 1
// - a locked OTP half can never be changed again
// - OTP programmed inside secured mode; main array blocked while in that mode
// - 512KB map: eight 64KB blocks, sixteen 32KB halves, 128 4KB sectors
// - unknown command: standby until next select fall, output kept high impedance
// - valid command: active until chip select rises
// - inputs sampled on clock rise, outputs shifted on fall; modes 0 and 3
// - data-returning commands may end after any output bit
// - state-changing commands need select rise on byte boundary, else rejected
// - array access ignored while a write, program or erase runs
// - pause starts on hold fall while clock low, else deferred until clock low
// - pause ends on hold rise while clock low, else deferred until clock low
// - pause stops serial traffic only; internal operations carry on
// - during pause output high impedance and input ignored
// - select rise during pause resets interface logic
// - pause disabled in four-line mode
// - data-changing commands refused while write-enable latch clear
// - program and erase aimed at protected blocks are refused
// - protect pin low with status write-disable bit set blocks protect-bit writes unless four-line mode
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
`define SFP_OP_WRITE_ENABLE_CMD      8'h06
`define SFP_OP_WRDI      8'h04
`define SFP_OP_RDSR      8'h05
`define SFP_OP_RDCR      8'h15
`define SFP_OP_WRSR      8'h01
`define SFP_OP_READ      8'h03
`define SFP_OP_FREAD     8'h0b
`define SFP_OP_PP        8'h02
`define SFP_OP_SE        8'h20
`define SFP_OP_BE32      8'h52
`define SFP_OP_BE64      8'hd8
`define SFP_OP_CE1       8'h60
`define SFP_OP_CE2       8'hc7
`define SFP_OP_RDSCUR    8'h2b
`define SFP_OP_SECURITY_REG_WRITE_CMD    8'h2f
`define SFP_OP_OTP_MODE_ENTER_CMD      8'hb1
`define SFP_OP_OTP_MODE_EXIT_CMD      8'hc1
`define SFP_ST_BUSY      0
`define SFP_ST_WEL       1
`define SFP_ST_BP_LO     2
`define SFP_ST_TB        6
`define SFP_ST_STATUS_WRITE_DISABLE      7
`define SFP_SCUR_FLOCK   0
`define SFP_SCUR_CLOCK   1
`define SFP_BLK_MSB      18
`define SFP_BLK_LSB      16
`define SFP_OTP_HALF     9
`define SFP_OTP_MSB      9
`define SFP_ADDR_BYTES   2'h3
`define SFP_LAST_BIT     3'h7
`endif

/* rtl/sfp_pkg.sv */
// types for the serial flash protect/hold front end
package sfp_pkg;
    typedef enum logic [5:0] {
        SFP_IDLE  = 6'h01,
        SFP_CMD   = 6'h02,
        SFP_ADDR  = 6'h04,
        SFP_DATA  = 6'h08,
        SFP_OUT   = 6'h10,
        SFP_STBY  = 6'h20
    } sfp_state_t;
    typedef enum logic [2:0] {
        SFP_K_NONE = 3'h0,
        SFP_K_PROG = 3'h1,
        SFP_K_ERASE = 3'h2,
        SFP_K_CHIP = 3'h3,
        SFP_K_WRSR = 3'h4,
        SFP_K_SIMPLE = 3'h5
    } sfp_kind_t;
endpackage

/* rtl/sfp_fifo.sv */
// small valid/ready FIFO
module sfp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;
    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // sfp_fifo

/* sim/sfp_front_monitor.sv */
// assertion checker for the serial front end
module sfp_front_monitor (
    // clock, reset and pins
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       cs_n,
    input wire logic       busy,
    input wire logic       so_oe,
    // outcomes
    input wire logic       erase_req,
    input wire logic [1:0] erase_size,
    input wire logic [7:0] status,
    input wire logic       paused,
    input wire logic       active,
    input wire logic       rejected
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // checks
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_pause_hiz: assert property (paused |-> !so_oe) else $error("pause drive");
    a_cs_idle: assert property (cs_n [*8] |-> !paused && !active) else $error("idle");
    a_chip_gate: assert property (erase_req && erase_size == 2'h3 |-> status[5:2] == 4'h0)
        else $error("chip gate");
    a_erase_pulse: assert property (erase_req |=> !erase_req) else $error("pulse");
    a_accept_clean: assert property (erase_req |-> !rejected) else $error("accept");
    a_busy_block: assert property (busy [*8] |-> !erase_req) else $error("busy");
    a_reject_hiz: assert property (rejected |-> !so_oe) else $error("reject drive");
    a_wel_drop: assert property (erase_req |-> ##[1:3] !status[1]) else $error("wel");
    c_chip: cover property (erase_req && erase_size == 2'h3);
    c_pause: cover property (paused);
    c_reject: cover property (rejected);
endmodule // sfp_front_monitor
bind sfp_front sfp_front_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .busy(busy),
    .so_oe(so_oe), .erase_req(erase_req), .erase_size(erase_size), .status(status),
    .paused(paused), .active(active), .rejected(rejected));

/* sim/sfp_host_model.sv */
// host controller model: mode 0 frames with optional pause
module sfp_host_model (
    // pins toward the device
    input  wire logic ref_clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    output logic      hold_n,
    // data back from the device
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rx = 32'h0;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask
    // clock rests low outside frames
    task automatic frame(input logic [39:0] d, input int n, input int p);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i];
            half();
            if (i == p) begin
                hold_n = 1'b0;
                si = ~si;
                repeat (4) half();
                hold_n = 1'b1;
                si = d[i];
                half();
            end
            rx = {rx[30:0], so};
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si = ~si;
        repeat (4) half();
    endtask
endmodule // sfp_host_model

/* sim/tb_top.sv */
// testbench for the serial front end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst, busy, cs_n, sclk, si, hold_n, so, so_oe;
    logic        erase_req, prog_start, otp_mode, otp_select, prog_valid;
    logic        customer_lock, paused, active, rejected;
    logic        paused_seen = 1'b0;
    logic        flock = 1'b0, wp_n = 1'b1;
    logic [1:0]  erase_size;
    logic [7:0]  prog_data, status, exp_erase;
    logic [7:0]  n_erase = 8'h00;
    logic [7:0]  n_prog = 8'h00, last_prog = 8'h00;
    logic [18:0] op_addr;
    int          failures = 0, tests_run = 0, cycles = 0;
    sfp_host_model i_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .hold_n(hold_n), .so(so));
    sfp_front i_dut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n),
        .hold_n(hold_n), .so(so), .so_oe(so_oe), .quad_mode(1'b0), .busy(busy), .factory_lock(flock),
        .read_data(8'h00), .erase_req(erase_req), .erase_size(erase_size), .prog_start(prog_start),
        .op_addr(op_addr), .otp_mode(otp_mode), .otp_select(otp_select), .prog_data(prog_data),
        .prog_valid(prog_valid), .prog_ready(1'b1), .status(status), .customer_lock(customer_lock),
        .paused(paused), .active(active), .rejected(rejected));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // hang guard well above the run's few thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (erase_req) n_erase <= n_erase + 8'h01;
        if (paused) paused_seen <= 1'b1;
        if (prog_start) n_prog <= n_prog + 8'h01;
        if (prog_valid) last_prog <= prog_data;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // optional write enable, one frame, then refusal flag and erase count
    task automatic run(input logic w, input logic [39:0] d, input int n, input int p, input logic rej,
                       input logic er);
        if (w) i_host.frame(32'h06, 8, -1);
        i_host.frame(d, n, p);
        exp_erase = exp_erase + {7'h00, er};
        chk({rejected, n_erase}, {rej, exp_erase});
    endtask
    task automatic t_walk();
        chk(status, 8'h00);
        run(1, 32'h2007_f123, 32, -1, 0, 1);
        chk({erase_size, op_addr}, {2'h0, 19'h7f123});
        chk(status[1], 1'b0);
        run(1, 32'h60, 8, -1, 0, 1);
        chk(erase_size, 2'h3);
    endtask
    task automatic t_refuse();
        run(0, 32'h2000_0000, 32, -1, 1, 0);
        run(1, 32'h1000_0000, 31, -1, 1, 0);
        busy = 1'b1;
        run(1, 32'h2000_0000, 32, -1, 1, 0);
        busy = 1'b0;
    endtask
    task automatic t_pause();
        run(1, 32'h2000_0000, 32, 12, 0, 1);
        chk(paused_seen, 1'b1);
    endtask
    task automatic t_protect();
        run(1, 32'h0104, 16, -1, 0, 0);
        chk(status[5:2], 4'h1);
        run(1, 32'h60, 8, -1, 1, 0);
        run(1, 32'hd807_0000, 32, -1, 1, 0);
        run(1, 32'hd806_0000, 32, -1, 0, 1);
        run(1, 32'h014c, 16, -1, 0, 0);
        run(1, 32'hd800_0000, 32, -1, 1, 0);
        run(1, 32'hd807_0000, 32, -1, 0, 1);
        chk(erase_size, 2'h2);
        run(1, 32'h01cc, 16, -1, 0, 0);
        wp_n = 1'b0;
        run(1, 32'h0100, 16, -1, 1, 0);
        wp_n = 1'b1;
    endtask
    task automatic t_otp();
        i_host.frame(32'h0500, 16, -1);
        chk(i_host.rx[7:0], 8'hce);
        run(0, 32'hb1, 8, -1, 0, 0);
        chk(otp_mode, 1'b1);
        run(1, 32'hd807_0000, 32, -1, 1, 0);
        flock = 1'b1;
        run(1, 40'h02_0002_00a5, 40, -1, 1, 0);
        chk(otp_select, 1'b1);
        run(1, 40'h02_0700_005a, 40, -1, 0, 0);
        chk(op_addr, 19'h0);
        chk({n_prog, last_prog}, {8'h01, 8'h5a});
        run(1, 32'h2f, 8, -1, 0, 0);
        chk(customer_lock, 1'b1);
        run(1, 40'h02_0000_00a5, 40, -1, 1, 0);
        i_host.frame(32'h2b00, 16, -1);
        chk(i_host.rx[7:0], 8'h03);
        run(0, 32'hc1, 8, -1, 0, 0);
        chk(otp_mode, 1'b0);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        busy = 1'b0;
        exp_erase = 8'h00;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_walk();
        t_refuse();
        t_pause();
        t_protect();
        t_otp();
        tally_and_finish();
    end
endmodule // tb_top
